// ===== core_pkg.sv
// Shared constants for the core storage parity and sharing control.
package core_pkg;

	localparam int CLK_NS      = 25;
	localparam int CYCLE_NS    = 1750;
	localparam int CYC_CLKS    = (CYCLE_NS + CLK_NS - 1) / CLK_NS;

	localparam int INFO_W      = 24;
	localparam int GRP_W       = 6;
	localparam int GRP_N       = 4;
	localparam int WORD_W      = 28;
	localparam int PAR_LSB     = 24;
	localparam int S_W         = 13;
	localparam int FIELD_BIT   = 12;
	localparam int FIELD_WORDS = 4096;
	localparam int FIELDS      = 2;
	localparam int DEPTH       = FIELD_WORDS * FIELDS;
	localparam int REQ_N       = 4;

	localparam logic [7:0] OFS_CTRL   = 8'h00;
	localparam logic [7:0] OFS_STATUS = 8'h04;
	localparam logic [7:0] OFS_ADDR   = 8'h08;
	localparam logic [7:0] OFS_RESTORE = 8'h0C;
	localparam logic [7:0] OFS_FAULT  = 8'h10;

	localparam int CTRL_SEL_LSB   = 0;
	localparam int STAT_PERR      = 0;
	localparam int STAT_HALT      = 1;
	localparam int STAT_BUSY      = 2;
	localparam int STAT_COMP      = 3;
	localparam int STAT_DIS       = 4;
	localparam int STAT_GRP_LSB   = 8;

	localparam logic [1:0] SEL_LEFT   = 2'h0;
	localparam logic [1:0] SEL_SHARED = 2'h1;
	localparam logic [1:0] SEL_RIGHT  = 2'h2;

	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [1:0] {ST_IDLE, ST_READ, ST_HOLD, ST_WRITE} cyc_st_t;

endpackage

// ===== core_props.sv
// Concurrent checks on the core storage control ports.
`timescale 1ns/100ps
`default_nettype none
module core_props
	import core_pkg::*;
#(
	parameter int CYCLE_CLKS = CYC_CLKS
) (
	input wire logic              aclk,
	input wire logic              aresetn,
	input wire logic [REQ_N-1:0]  req,
	input wire logic [REQ_N-1:0]  ack,
	input wire logic [INFO_W-1:0] rdata,
	input wire logic [GRP_N-1:0]  rpar,
	input wire logic              mem_fault,
	input wire logic              program_halt,
	input wire logic              parity_err_ind,
	input wire logic [7:0]        s_axi_awaddr,
	input wire logic              s_axi_awvalid,
	input wire logic              s_axi_awready,
	input wire logic [31:0]       s_axi_wdata,
	input wire logic [3:0]        s_axi_wstrb,
	input wire logic              s_axi_wvalid,
	input wire logic              s_axi_wready
);
	localparam int W = CYCLE_CLKS + 2;
	logic [1:0] sel_r;
	logic       shared;
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	// Tracks the selector from register bus writes whose address and data are accepted in the same cycle.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			sel_r <= SEL_SHARED;
		end else if (s_axi_awvalid && s_axi_awready && s_axi_wvalid &&
			s_axi_wready && s_axi_awaddr == OFS_CTRL && s_axi_wstrb[0]) begin
			sel_r <= s_axi_wdata[1:0];
		end
	end
	assign shared = sel_r == SEL_SHARED || sel_r == 2'h3;
	AST_ACK_ONEHOT: assert property ($onehot0(ack))
		else $error("ack to several requesters");
	AST_ACK_GAP: assert property (|ack |=> ack == 4'h0)
		else $error("ack longer than one cycle");
	AST_ACK_CAUSE: assert property (|ack |-> (ack & $past(req, CYCLE_CLKS)) == ack)
		else $error("ack without a held request");
	AST_RPAR_ODD: assert property (|ack |-> rpar == ~{^rdata[23:18], ^rdata[17:12], ^rdata[11:6], ^rdata[5:0]})
		else $error("group parity not odd");
	AST_FAULT_IND: assert property (mem_fault == parity_err_ind)
		else $error("fault and indicator differ");
	AST_HALT_CAUSE: assert property (program_halt |-> mem_fault)
		else $error("halt without fault");
	AST_HOLD: assert property (!(|ack) |-> $stable(rdata) && $stable(rpar))
		else $error("read word changed without ack");
	AST_LEFT_ONLY: assert property (sel_r == SEL_LEFT && $past(sel_r, W) == SEL_LEFT |-> ack[3:2] == 2'h0)
		else $error("right served in left mode");
	AST_RIGHT_ONLY: assert property (sel_r == SEL_RIGHT && $past(sel_r, W) == SEL_RIGHT |-> ack[1:0] == 2'h0)
		else $error("left served in right mode");
	AST_L2R: assert property (shared && |ack[1:0] && |req[3:2] |=> (ack[1:0] == 2'h0) throughout (##[0:W] |ack[3:2]))
		else $error("right not served next");
	AST_R2L: assert property (shared && |ack[3:2] && |req[1:0] |=> (ack[3:2] == 2'h0) throughout (##[0:W] |ack[1:0]))
		else $error("left not served next");
endmodule
bind core_storage_parity_share_control core_props #(
	.CYCLE_CLKS(CYCLE_CLKS)
) core_props_inst (
	.aclk, .aresetn, .req, .ack, .rdata, .rpar, .mem_fault, .program_halt,
	.parity_err_ind, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
	.s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready
);
`default_nettype wire

// ===== core_storage_parity_share_control.sv
// Core storage module control: parity, sharing scanners and AXI4-Lite.
`timescale 1ns/100ps
`default_nettype none
// Function
// - Each word holds 28 bits.
// - Four 6-bit groups, one parity bit each.
// - Write cycle generates and stores group parity.
// - Parity is odd per group.
// - Read delivers parity bits with data.
// - Parity mismatch flags fault and halts.
// - Disable switch prevents the parity halt.
// - Parity error indicator output is driven.
// - End positions grant one computer exclusively.
// - Middle position scans both without priority.
// - Served computer yields at cycle end.
// - Waiting computer delayed one cycle at most.
// - Inner scanner picks main or block control.
// - Address register 13 bits, bit 12 field.
// - 28-bit restore register holds read word.
// - Fields of 4,096 words form one space.
// - Normal cycle reads then restores word unchanged.
// - Restore register cleared after write unless halted.
module core_storage_parity_share_control
	import core_pkg::*;
#(
	parameter int CYCLE_CLKS = CYC_CLKS
) (
	input  wire logic                        aclk,
	input  wire logic                        aresetn,
	input  wire logic [REQ_N-1:0]            req,
	input  wire logic [REQ_N-1:0]            req_wr,
	input  wire logic [REQ_N-1:0][S_W-1:0]   req_addr,
	input  wire logic [REQ_N-1:0][INFO_W-1:0] req_wdata,
	output logic      [REQ_N-1:0]            ack,
	output logic      [INFO_W-1:0]           rdata,
	output logic      [GRP_N-1:0]            rpar,
	input  wire logic                        parity_disable_sw,
	output logic                             mem_fault,
	output logic                             program_halt,
	output logic                             parity_err_ind,
	input  wire logic [7:0]                  s_axi_awaddr,
	input  wire logic                        s_axi_awvalid,
	output logic                             s_axi_awready,
	input  wire logic [31:0]                 s_axi_wdata,
	input  wire logic [3:0]                  s_axi_wstrb,
	input  wire logic                        s_axi_wvalid,
	output logic                             s_axi_wready,
	output logic      [1:0]                  s_axi_bresp,
	output logic                             s_axi_bvalid,
	input  wire logic                        s_axi_bready,
	input  wire logic [7:0]                  s_axi_araddr,
	input  wire logic                        s_axi_arvalid,
	output logic                             s_axi_arready,
	output logic      [31:0]                 s_axi_rdata,
	output logic      [1:0]                  s_axi_rresp,
	output logic                             s_axi_rvalid,
	input  wire logic                        s_axi_rready
);
	localparam int CW = $clog2(CYCLE_CLKS + 1);

	function automatic logic [GRP_N-1:0] gen_par(
		input logic [INFO_W-1:0] d
	);
		logic [GRP_N-1:0] p;
		p = '0;
		for (int g = 0; g < GRP_N; g++) begin
			p[g] = ~(^d[g*GRP_W +: GRP_W]);
		end
		return p;
	endfunction

	function automatic logic known_ofs(input logic [7:0] a);
		return (a == OFS_CTRL) || (a == OFS_STATUS) || (a == OFS_ADDR)
			|| (a == OFS_RESTORE) || (a == OFS_FAULT);
	endfunction

	logic [WORD_W-1:0] core_mem [DEPTH];

	cyc_st_t           st_r;
	logic [CW-1:0]     cnt_r;
	logic [S_W-1:0]    s_r, fault_addr_r;
	logic [WORD_W-1:0] z_r;
	logic [INFO_W-1:0] wd_r, rdata_r;
	logic [REQ_N-1:0]  ack_r;
	logic [GRP_N-1:0]  rpar_r, grp_r, mism;
	logic [1:0]        sel_r, idx;
	logic              op_wr_r, comp_r, unit_r, perr_r, halt_r;
	logic              dis_s1_r, dis_s2_r, dis_s3_r, dis_r;
	logic              start, cyc_end, check, clr_fault;

	scan_if sc_c ();
	scan_if sc_l ();
	scan_if sc_r ();

	share_scanner u_scan_comp (.aclk(aclk), .aresetn(aresetn), .sc(sc_c));
	share_scanner u_scan_left (.aclk(aclk), .aresetn(aresetn), .sc(sc_l));
	share_scanner u_scan_right (.aclk(aclk), .aresetn(aresetn), .sc(sc_r));

	// Computer level requests, masked by the sharing selector.
	always_comb begin
		sc_c.req[0] = (|req[1:0]) && (sel_r != SEL_RIGHT);
		sc_c.req[1] = (|req[3:2]) && (sel_r != SEL_LEFT);
		sc_c.adv    = cyc_end;
		sc_c.served = comp_r;
		sc_l.req    = req[1:0];
		sc_l.adv    = cyc_end && !comp_r;
		sc_l.served = unit_r;
		sc_r.req    = req[3:2];
		sc_r.adv    = cyc_end && comp_r;
		sc_r.served = unit_r;
	end

	always_comb begin
		idx[1] = sc_c.gnt_idx;
		idx[0] = sc_c.gnt_idx ? sc_r.gnt_idx : sc_l.gnt_idx;
	end

	assign start   = (st_r == ST_IDLE) && !halt_r && sc_c.gnt_vld;
	assign cyc_end = (st_r == ST_WRITE);
	assign check   = (st_r == ST_HOLD) && (cnt_r == CW'(1)) && !op_wr_r;
	assign mism    = gen_par(z_r[INFO_W-1:0]) ^ z_r[WORD_W-1:PAR_LSB];

	// Storage cycle sequencing, one full cycle per granted request.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			st_r  <= ST_IDLE;
			cnt_r <= '0;
		end else begin
			case (st_r)
				ST_IDLE: begin
					cnt_r <= '0;
					if (start) begin
						st_r <= ST_READ;
					end
				end
				ST_READ: begin
					cnt_r <= cnt_r + CW'(1);
					st_r  <= ST_HOLD;
				end
				ST_HOLD: begin
					cnt_r <= cnt_r + CW'(1);
					if (cnt_r >= CW'(CYCLE_CLKS - 2)) begin
						st_r <= ST_WRITE;
					end
				end
				default: begin
					cnt_r <= '0;
					st_r  <= ST_IDLE;
				end
			endcase
		end
	end

	// Requester captured at the start of a cycle.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_r     <= '0;
			wd_r    <= '0;
			op_wr_r <= 1'b0;
			comp_r  <= 1'b0;
			unit_r  <= 1'b0;
		end else if (start) begin
			s_r     <= req_addr[idx];
			wd_r    <= req_wdata[idx];
			op_wr_r <= req_wr[idx];
			comp_r  <= idx[1];
			unit_r  <= idx[0];
		end
	end

	// Restore register: read out, modify on write, cleared after write-back unless halted.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			z_r <= '0;
		end else if (st_r == ST_READ) begin
			z_r <= core_mem[s_r];
		end else if ((st_r == ST_HOLD) && (cnt_r == CW'(1)) && op_wr_r) begin
			z_r <= {gen_par(wd_r), wd_r};
		end else if (cyc_end && !halt_r) begin
			z_r <= '0;
		end
	end

	// Write-back of the whole word, parity included.
	always_ff @(posedge aclk) begin
		if (cyc_end) begin
			core_mem[s_r] <= z_r;
		end
	end

	// Answer to the served requester with data and its parity bits.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ack_r   <= '0;
			rdata_r <= '0;
			rpar_r  <= '0;
		end else begin
			ack_r <= '0;
			if (cyc_end) begin
				ack_r[{comp_r, unit_r}] <= 1'b1;
				rdata_r <= z_r[INFO_W-1:0];
				rpar_r  <= z_r[WORD_W-1:PAR_LSB];
			end
		end
	end

	// Disable switch passes four flip-flops; the last loads only when the two before it agree.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			dis_s1_r <= 1'b0;
			dis_s2_r <= 1'b0;
			dis_s3_r <= 1'b0;
			dis_r    <= 1'b0;
		end else begin
			dis_s1_r <= parity_disable_sw;
			dis_s2_r <= dis_s1_r;
			dis_s3_r <= dis_s2_r;
			if (dis_s2_r == dis_s3_r) begin
				dis_r <= dis_s3_r;
			end
		end
	end

	// Parity fault flags; a new fault wins over a software clear.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			perr_r <= 1'b0;
			halt_r <= 1'b0;
		end else begin
			if (check && (mism != '0)) begin
				perr_r <= 1'b1;
			end else if (clr_fault) begin
				perr_r <= 1'b0;
			end
			if (check && (mism != '0) && !dis_r) begin
				halt_r <= 1'b1;
			end else if (clr_fault) begin
				halt_r <= 1'b0;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			grp_r        <= '0;
			fault_addr_r <= '0;
		end else if (check && (mism != '0)) begin
			grp_r        <= mism;
			fault_addr_r <= s_r;
		end
	end

	assign ack            = ack_r;
	assign rdata          = rdata_r;
	assign rpar           = rpar_r;
	assign mem_fault      = perr_r;
	assign program_halt   = halt_r;
	assign parity_err_ind = perr_r;

	// AXI4-Lite slave: address and data taken in either order.
	logic              aw_got_r, w_got_r, bvalid_r, rvalid_r, do_wr;
	logic [7:0]        awaddr_r;
	logic [31:0]       wdata_r, rdat_r, status;
	logic [3:0]        wstrb_r;
	logic [1:0]        bresp_r, rresp_r;

	assign s_axi_awready = !aw_got_r && !bvalid_r;
	assign s_axi_wready  = !w_got_r && !bvalid_r;
	assign s_axi_arready = !rvalid_r;
	assign s_axi_bvalid  = bvalid_r;
	assign s_axi_bresp   = bresp_r;
	assign s_axi_rvalid  = rvalid_r;
	assign s_axi_rresp   = rresp_r;
	assign s_axi_rdata   = rdat_r;
	assign do_wr         = aw_got_r && w_got_r && !bvalid_r;
	assign clr_fault     = do_wr && (awaddr_r == OFS_STATUS)
		&& wstrb_r[0] && wdata_r[STAT_PERR];

	always_comb begin
		status                     = '0;
		status[STAT_PERR]          = perr_r;
		status[STAT_HALT]          = halt_r;
		status[STAT_BUSY]          = (st_r != ST_IDLE);
		status[STAT_COMP]          = comp_r;
		status[STAT_DIS]           = dis_r;
		status[STAT_GRP_LSB +: GRP_N] = grp_r;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_got_r <= 1'b0;
			awaddr_r <= '0;
		end else if (s_axi_awvalid && s_axi_awready) begin
			aw_got_r <= 1'b1;
			awaddr_r <= s_axi_awaddr;
		end else if (do_wr) begin
			aw_got_r <= 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			w_got_r <= 1'b0;
			wdata_r <= '0;
			wstrb_r <= '0;
		end else if (s_axi_wvalid && s_axi_wready) begin
			w_got_r <= 1'b1;
			wdata_r <= s_axi_wdata;
			wstrb_r <= s_axi_wstrb;
		end else if (do_wr) begin
			w_got_r <= 1'b0;
		end
	end

	// Register writes and the write response.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			sel_r    <= SEL_SHARED;
			bvalid_r <= 1'b0;
			bresp_r  <= RESP_OKAY;
		end else if (do_wr) begin
			bvalid_r <= 1'b1;
			bresp_r  <= RESP_OKAY;
			if (!known_ofs(awaddr_r)) begin
				bresp_r <= RESP_SLVERR;
			end else if ((awaddr_r == OFS_CTRL) && wstrb_r[0]) begin
				sel_r <= wdata_r[CTRL_SEL_LSB +: 2];
			end
		end else if (s_axi_bready) begin
			bvalid_r <= 1'b0;
		end
	end

	// Register reads.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rvalid_r <= 1'b0;
			rresp_r  <= RESP_OKAY;
			rdat_r   <= '0;
		end else if (s_axi_arvalid && s_axi_arready) begin
			rvalid_r <= 1'b1;
			rresp_r  <= RESP_OKAY;
			if (s_axi_araddr == OFS_CTRL) begin
				rdat_r <= {30'h0000_0000, sel_r};
			end else if (s_axi_araddr == OFS_STATUS) begin
				rdat_r <= status;
			end else if (s_axi_araddr == OFS_ADDR) begin
				rdat_r <= {19'h0_0000, s_r};
			end else if (s_axi_araddr == OFS_RESTORE) begin
				rdat_r <= {4'h0, z_r};
			end else if (s_axi_araddr == OFS_FAULT) begin
				rdat_r <= {19'h0_0000, fault_addr_r};
			end else begin
				rdat_r  <= '0;
				rresp_r <= RESP_SLVERR;
			end
		end else if (s_axi_rready) begin
			rvalid_r <= 1'b0;
		end
	end
endmodule
`default_nettype wire

// ===== req_model.sv
// Model of the main and block control requesters of both computers.
`timescale 1ns/100ps
`default_nettype none
module req_model
	import core_pkg::*;
(
	input  wire logic [0:0]                   aclk,
	input  wire logic                         aresetn,
	input  wire logic [REQ_N-1:0]             start,
	input  wire logic                         wr_in,
	input  wire logic [S_W-1:0]               addr_in,
	input  wire logic [INFO_W-1:0]            wdata_in,
	input  wire logic [REQ_N-1:0]             ack,
	output logic      [REQ_N-1:0]             req,
	output logic      [REQ_N-1:0]             req_wr,
	output logic      [REQ_N-1:0][S_W-1:0]    req_addr,
	output logic      [REQ_N-1:0][INFO_W-1:0] req_wdata
);
	logic [REQ_N-1:0]             pend_r, wr_r;
	logic [REQ_N-1:0][S_W-1:0]    addr_r;
	logic [REQ_N-1:0][INFO_W-1:0] data_r;
	always_ff @(posedge aclk) begin
		for (int i = 0; i < REQ_N; i++) begin
			if (!aresetn) begin
				pend_r[i] <= 1'b0;
				wr_r[i] <= 1'b0;
				addr_r[i] <= '0;
				data_r[i] <= '0;
			end else if (start[i]) begin
				pend_r[i] <= 1'b1;
				wr_r[i] <= wr_in;
				addr_r[i] <= addr_in;
				data_r[i] <= wdata_in;
			end else if (ack[i]) begin
				pend_r[i] <= 1'b0;
			end
		end
	end
	// Request drops in its ack cycle; idle qualifiers show no stale value.
	always_comb begin
		for (int i = 0; i < REQ_N; i++) begin
			req[i] = pend_r[i] & ~ack[i];
			req_wr[i] = pend_r[i] ? wr_r[i] : ~wr_r[i];
			req_addr[i] = pend_r[i] ? addr_r[i] : ~addr_r[i];
			req_wdata[i] = pend_r[i] ? data_r[i] : ~data_r[i];
		end
	end
endmodule
`default_nettype wire

// ===== scan_if.sv
// Request and grant signals between the control and a two-way scanner.
`timescale 1ns/100ps
`default_nettype none
interface scan_if;
	logic [1:0] req;
	logic       adv;
	logic       served;
	logic       gnt_vld;
	logic       gnt_idx;
	modport arb (input req, input adv, input served,
		output gnt_vld, output gnt_idx);
	modport user (output req, output adv, output served,
		input gnt_vld, input gnt_idx);
endinterface
`default_nettype wire

// ===== share_scanner.sv
// Two-way scanner that alternates between two requesters.
`timescale 1ns/100ps
`default_nettype none
module share_scanner (
	input  wire logic aclk,
	input  wire logic aresetn,
	scan_if.arb       sc
);
	logic ptr_r;

	// The favoured side goes first; the other is served if it alone asks.
	always_comb begin
		sc.gnt_vld = |sc.req;
		if (sc.req[ptr_r]) begin
			sc.gnt_idx = ptr_r;
		end else if (sc.req[~ptr_r]) begin
			sc.gnt_idx = ~ptr_r;
		end else begin
			sc.gnt_idx = ptr_r;
		end
	end

	// The side just served yields the next cycle to the other.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ptr_r <= 1'b0;
		end else if (sc.adv) begin
			ptr_r <= ~sc.served;
		end
	end
endmodule
`default_nettype wire

// ===== tb.sv
// Self-checking bench for the core storage control.
`timescale 1ns/100ps
`default_nettype none
module tb import core_pkg::*;;
	localparam int CYC = 4;
	typedef struct packed {
		logic [1:0]        u;
		logic              wr;
		logic [S_W-1:0]    a;
		logic [INFO_W-1:0] d;
	} row_t;
	logic aclk = 1'b0, aresetn = 1'b0, wr_in = 1'b0, parity_disable_sw = 1'b0;
	logic [REQ_N-1:0]             start = '0, req, req_wr, ack;
	logic [S_W-1:0]               addr_in = '0;
	logic [INFO_W-1:0]            wdata_in = '0, rdata;
	logic [REQ_N-1:0][S_W-1:0]    req_addr;
	logic [REQ_N-1:0][INFO_W-1:0] req_wdata;
	logic [GRP_N-1:0]             rpar;
	logic mem_fault, program_halt, parity_err_ind;
	logic [7:0]  s_axi_awaddr = '0, s_axi_araddr = '0;
	logic [31:0] s_axi_wdata = '0, s_axi_rdata;
	logic [3:0]  s_axi_wstrb = '0;
	logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
	logic s_axi_rvalid;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	int miscompares = 0, num_checks = 0;
	row_t rows [10] = '{
		{2'h0, 1'b1, 13'h0000, 24'hab_cdef}, {2'h1, 1'b1, 13'h0fff, 24'h00_0000},
		{2'h2, 1'b1, 13'h1000, 24'hff_ffff}, {2'h3, 1'b1, 13'h1fff, 24'h3f_0001},
		{2'h2, 1'b0, 13'h0000, 24'hab_cdef}, {2'h3, 1'b0, 13'h0fff, 24'h00_0000},
		{2'h0, 1'b0, 13'h1000, 24'hff_ffff}, {2'h1, 1'b0, 13'h1fff, 24'h3f_0001},
		{2'h0, 1'b0, 13'h0000, 24'hab_cdef}, {2'h1, 1'b0, 13'h1fff, 24'h3f_0001}};
	core_storage_parity_share_control #(
		.CYCLE_CLKS(CYC)
	) core_storage_parity_share_control_inst (
		.aclk, .aresetn, .req, .req_wr, .req_addr, .req_wdata, .ack, .rdata,
		.rpar, .parity_disable_sw, .mem_fault, .program_halt, .parity_err_ind,
		.s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
		.s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
		.s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
		.s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
		.s_axi_rready
	);
	req_model req_model_inst (
		.aclk, .aresetn, .start, .wr_in, .addr_in, .wdata_in, .ack, .req,
		.req_wr, .req_addr, .req_wdata
	);
	always #12.5 aclk = ~aclk;
	function automatic logic [3:0] opar(input logic [INFO_W-1:0] d);
		for (int g = 0; g < GRP_N; g++) opar[g] = ~^d[g*GRP_W +: GRP_W];
	endfunction
	task chk(input string n, input logic [31:0] e, input logic [31:0] g);
		num_checks++;
		if (g !== e) begin
			miscompares++;
			$display("mismatch %s expected %h seen %h", n, e, g);
		end
	endtask
	task finish_test;
		$display("checks %0d mismatches %0d", num_checks, miscompares);
		if (miscompares == 0 && num_checks > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask
	task issue(input logic [3:0] m, input logic w, input logic [S_W-1:0] a,
		input logic [INFO_W-1:0] d);
		@(posedge aclk);
		start <= m;
		wr_in <= w;
		addr_in <= a;
		wdata_in <= d;
		@(posedge aclk);
		start <= '0;
	endtask
	task wait_ack(input int u);
		do @(posedge aclk); while (ack[u] !== 1'b1);
	endtask
	task axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		logic aw, w;
		aw = 1'b1;
		w = 1'b1;
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_wstrb <= 4'hf;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		while (aw || w) begin
			@(posedge aclk);
			if (aw && s_axi_awready) begin
				aw = 1'b0;
				s_axi_awvalid <= 1'b0;
			end
			if (w && s_axi_wready) begin
				w = 1'b0;
				s_axi_wvalid <= 1'b0;
			end
		end
		while (s_axi_bvalid !== 1'b1) @(posedge aclk);
		r = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask
	task axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do @(posedge aclk); while (s_axi_arready !== 1'b1);
		s_axi_arvalid <= 1'b0;
		do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
		d = s_axi_rdata;
		r = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask
	initial begin
		repeat (20000) @(posedge aclk);
		miscompares++;
		finish_test;
	end
	initial begin
		int seen;
		logic [31:0] d;
		logic [1:0] r;
		repeat (4) @(posedge aclk);
		aresetn <= 1'b1;
		chk("faults", 32'h0, {mem_fault, program_halt, parity_err_ind});
		axi_rd(OFS_CTRL, d, r);
		chk("selector", 32'h1, d);
		axi_rd(8'h14, d, r);
		chk("unmapped", RESP_SLVERR, r);
		axi_wr(8'h14, 32'h0000_0001, r);
		chk("unmapped write", RESP_SLVERR, r);
		foreach (rows[i]) begin
			issue(4'h1 << rows[i].u, rows[i].wr, rows[i].a, rows[i].d);
			wait_ack(rows[i].u);
			chk("rdata", rows[i].d, rdata);
			chk("rpar", opar(rows[i].d), rpar);
		end
		chk("no fault", 32'h0, {mem_fault, program_halt, parity_err_ind});
		axi_rd(OFS_ADDR, d, r);
		chk("address", 32'h0000_1fff, d);
		axi_rd(OFS_RESTORE, d, r);
		chk("restore", 32'h0, d);
		parity_disable_sw <= 1'b1;
		repeat (6) @(posedge aclk);
		axi_rd(OFS_STATUS, d, r);
		chk("status", 32'h10, d & 32'h13);
		parity_disable_sw <= 1'b0;
		aresetn <= 1'b0;
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		chk("rdata reset", 32'h0, rdata);
		issue(4'hf, 1'b1, 13'h0abc, 24'h12_3456);
		for (int k = 0; k < 4; k++) begin
			do @(posedge aclk); while (ack === 4'h0);
			chk("order", 16'h8241 >> (4 * k) & 16'hf, ack);
		end
		for (int k = 0; k < 2; k++) begin
			axi_wr(OFS_CTRL, k ? 32'h2 : 32'h0, r);
			chk("bresp", RESP_OKAY, r);
			issue(4'h5, 1'b0, 13'h0abc, 24'h0);
			wait_ack(k * 2);
			seen = 0;
			repeat (3 * CYC) begin
				@(posedge aclk);
				if (ack[2 - k * 2]) seen++;
			end
			chk("blocked", 32'h0, seen);
			axi_wr(OFS_CTRL, 32'h1, r);
			wait_ack(2 - k * 2);
			chk("shared", 32'h12_3456, rdata);
		end
		finish_test;
	end
endmodule
`default_nettype wire
